// File: rtl/qpv_consts.vh
// Constants for the quadrature position and velocity block.
// Assumes inclusion by the design files of this block only.
`ifndef QPV_CONSTS_VH
`define QPV_CONSTS_VH

// Byte offsets of the AHB-Lite register words.
`define QPV_OFS_CONTROL 8'h00
`define QPV_OFS_STATUS 8'h04
`define QPV_OFS_POSITION 8'h08
`define QPV_OFS_LIMIT 8'h0c
`define QPV_OFS_VELOCITY 8'h10
`define QPV_OFS_TIMER 8'h14

// Field positions in the control word.
`define QPV_CTL_DIV_LSB 0
`define QPV_CTL_MODE_LSB 2
`define QPV_CTL_VDIS_BIT 7

// Field positions in the status word (flags write one to clear; the up bit is read-only).
`define QPV_ST_POS_BIT 0
`define QPV_ST_DIR_BIT 1
`define QPV_ST_ERR_BIT 2
`define QPV_ST_VEL_BIT 3
`define QPV_ST_UP_BIT 4

// Encoder mode codes.
`define QPV_MODE_OFF 3'h0
`define QPV_MODE_X2_INDEX 3'h1
`define QPV_MODE_X2_PERIOD 3'h2
`define QPV_MODE_X4_INDEX 3'h5
`define QPV_MODE_X4_PERIOD 3'h6

// Reset values.
`define QPV_RST_CONTROL 8'h00
`define QPV_RST_LIMIT 16'hffff

// Postscaler terminal counts for the four divide ratios.
`define QPV_DIV1_LAST 6'h00
`define QPV_DIV4_LAST 6'h03
`define QPV_DIV16_LAST 6'h0f
`define QPV_DIV64_LAST 6'h3f

`endif

// File: rtl/qpv_postscale.v
// Velocity pulse postscaler: one output pulse per 1, 4, 16 or 64 inputs.
// Assumes single-cycle input pulses on the same clock.
`timescale 1ns/10ps
`include "qpv_consts.vh"
module qpv_postscale (
    input wire clk,
    input wire rst,
    input wire enable,
    input wire [1:0] ratio,
    input wire pulse_in,
    output reg pulse_out
);
    // Count of input pulses since the last output.
    reg [5:0] count_q;
    // Terminal count selected by the ratio.
    reg [5:0] last_c;

    // Map the ratio code onto its terminal count.
    always @* begin
        case (ratio)
            2'h0: last_c = `QPV_DIV1_LAST;
            2'h1: last_c = `QPV_DIV4_LAST;
            2'h2: last_c = `QPV_DIV16_LAST;
            default: last_c = `QPV_DIV64_LAST;
        endcase
    end

    // Count input pulses and emit one on the terminal count.
    // The count is held while disabled so settings resume as before.
    always @(posedge clk) begin
        if (rst) begin
            count_q <= 6'h00;
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= 1'b0;
            if (enable && pulse_in) begin
                if (count_q >= last_c) begin
                    count_q <= 6'h00;
                    pulse_out <= 1'b1;
                end else begin
                    count_q <= count_q + 6'h01;
                end
            end
        end
    end
endmodule

// File: rtl/qpv_sync.v
// Two flip-flop synchroniser for one asynchronous input.
// Assumes the input is a pin outside the clk domain.
`timescale 1ns/10ps
module qpv_sync (
    input wire clk,
    input wire rst,
    input wire pin_in,
    output wire sync_out
);
    // First stage, read only by the second stage.
    reg meta_q;
    // Second stage, the safe synchronised level.
    reg sync_q;

    // Shift the pin through both stages every clock.
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: rtl/qpv_top.v
// Quadrature encoder position and velocity block with AHB-Lite registers.
// Assumes raw encoder pins asynchronous to clk and a single AHB master.
//
// Summary of operation
// [RULE1] x2 mode counts both phase_a edges only
// [RULE2] x4 mode counts every edge of both
// [RULE3] Phase_a leading sets direction and counts up
// [RULE4] Step chosen from previous edge pairing
// [RULE5] Forward index rising clears count next edge
// [RULE6] Reverse index falling loads limit next edge
// [RULE7] Forward match clears count, event follows
// [RULE8] Reverse at zero loads limit, event follows
// [RULE9] Mode change or off keeps count
// [RULE10] Position event on match, rollover, index
// [RULE11] Direction change flag set next cycle
// [RULE12] Index mode rollover sets count error
// [RULE13] Internal position event pulse one cycle
// [RULE14] Software alone clears position event flag
// [RULE15] Encoder period at least sixteen cycles
// [RULE16] Phase inputs synchronised before edge detect
// [RULE17] Velocity on when enabled and mode active
// [RULE18] Capture buffer serves as velocity capture
// [RULE19] Velocity pulse on every active edge
// [RULE20] Divided pulse captures, then clears timer
// [RULE21] Mode codes decoded, others unused
// [RULE22] Velocity pulses divided 1, 4, 16, 64
// [RULE23] Mode off disables counting and velocity
// [RULE24] Sixteen-bit count compared with limit
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "qpv_consts.vh"
module qpv_top (
    input wire clk,
    input wire rst,
    input wire phase_a,
    input wire phase_b,
    input wire index_input,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output wire rotation_direction,
    output wire velocity_pulse
);
    // Synchronised encoder levels.
    wire a_s;
    wire b_s;
    wire i_s;
    // Previous synchronised levels for edge detection.
    reg a_q;
    reg b_q;
    reg i_q;
    // Last detected edge: bit 1 is 1 for phase_b, bit 0 is 1 for rising.
    reg [1:0] last_edge_q;
    // Direction status, 1 for forward.
    reg up_q;
    // Position counter, the integrated count of steps.
    reg [15:0] position_count_q;
    // Period limit, the count at which period modes wrap.
    reg [15:0] period_limit_q;
    // Index rising edge seen, waiting for the next phase edge.
    reg index_fwd_q;
    // Index falling edge seen, waiting for the next phase edge.
    reg index_rev_q;
    // Encoder mode code as last written; unused codes count as off.
    reg [2:0] mode_q;
    // Velocity pulse divide ratio code.
    reg [1:0] ratio_q;
    // Velocity measurement disable; 1 stops the postscaler and timer.
    reg velocity_disable_q;
    // Sticky flag: a position event, a counter reset or load.
    reg pos_flag_q;
    // Sticky flag: the direction of rotation changed.
    reg dir_flag_q;
    // Sticky flag: the counter rolled over in index mode.
    reg err_flag_q;
    // Sticky flag: a divided velocity pulse captured the timer.
    reg vel_flag_q;
    // One-cycle position event pulse, ahead of its flag.
    reg pos_evt_q;
    // One-cycle direction change pulse, ahead of its flag.
    reg dir_evt_q;
    // Speed timer, cleared on each capture.
    reg [15:0] speed_timer_q;
    // Timer value at the last divided velocity pulse.
    reg [15:0] velocity_capture_q;
    // A write data phase is under way this cycle.
    reg wr_pend_q;
    // Address of the transfer in its data phase.
    reg [7:0] addr_q;

    // Synchronise all three encoder pins.
    // [RULE16] Two-stage input sync
    qpv_sync u_sync_a (.clk(clk), .rst(rst), .pin_in(phase_a),
        .sync_out(a_s));
    qpv_sync u_sync_b (.clk(clk), .rst(rst), .pin_in(phase_b),
        .sync_out(b_s));
    qpv_sync u_sync_i (.clk(clk), .rst(rst), .pin_in(index_input),
        .sync_out(i_s));

    // Mode decode; unused codes behave as off.
    // [RULE21] Mode code decode
    wire mode_x2 = (mode_q == `QPV_MODE_X2_INDEX) ||
        (mode_q == `QPV_MODE_X2_PERIOD);
    wire mode_x4 = (mode_q == `QPV_MODE_X4_INDEX) ||
        (mode_q == `QPV_MODE_X4_PERIOD);
    wire mode_index = (mode_q == `QPV_MODE_X2_INDEX) ||
        (mode_q == `QPV_MODE_X4_INDEX);
    // [RULE23] Off disables all
    wire enabled = mode_x2 || mode_x4;

    // Edge detection on synchronised levels.
    wire a_edge = a_s ^ a_q;
    wire b_edge = b_s ^ b_q;
    wire i_rise = i_s & ~i_q;
    wire i_fall = ~i_s & i_q;

    // Direction from the previous edge pairing, for the current edge.
    // [RULE4] Previous-edge direction table
    reg dir_c;
    always @* begin
        dir_c = up_q;
        if (a_edge) begin
            // Phase_a rising after phase_b falling counts up.
            if (last_edge_q[1])
                dir_c = (a_s == ~last_edge_q[0]);
        end else if (b_edge) begin
            // Phase_b rising after phase_a rising counts up.
            if (!last_edge_q[1])
                dir_c = (b_s == last_edge_q[0]);
        end
    end

    // An edge that steps the counter in the current mode.
    // [RULE1] x2 uses phase_a only
    // [RULE2] x4 uses both phases
    wire step = enabled && (a_edge || (mode_x4 && b_edge));
    // [RULE19] Velocity pulse per step
    wire vel_raw = step;
    // [RULE17] Velocity enable condition
    wire vel_on = enabled && !velocity_disable_q;

    // [RULE24] Sixteen-bit match compare
    wire at_limit = (position_count_q == period_limit_q);
    wire at_zero = (position_count_q == 16'h0000);
    wire at_ones = (position_count_q == 16'hffff);
    // [RULE12] Index mode rollover error
    // A step past either end of the count while in index mode.
    wire err_set = step && mode_index &&
        ((dir_c && at_ones) || (!dir_c && at_zero));

    // Track edges, direction, and index arming.
    always @(posedge clk) begin
        if (rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            i_q <= 1'b0;
            last_edge_q <= 2'h0;
            up_q <= 1'b0;
            dir_evt_q <= 1'b0;
            index_fwd_q <= 1'b0;
            index_rev_q <= 1'b0;
        end else begin
            // Delay the synchronised levels by one clock.
            a_q <= a_s;
            b_q <= b_s;
            i_q <= i_s;
            dir_evt_q <= 1'b0;
            // Record the pin and polarity of the latest edge.
            if (a_edge)
                last_edge_q <= {1'b0, a_s};
            else if (b_edge)
                last_edge_q <= {1'b1, b_s};
            if (step) begin
                // [RULE3] Set direction status
                up_q <= dir_c;
                // [RULE11] Direction change event
                dir_evt_q <= (dir_c != up_q);
            end
            // Arm the index reset; the next step consumes it.
            if (enabled && mode_index && i_rise)
                index_fwd_q <= 1'b1;
            else if (step)
                index_fwd_q <= 1'b0;
            if (enabled && mode_index && i_fall)
                index_rev_q <= 1'b1;
            else if (step)
                index_rev_q <= 1'b0;
        end
    end

    // Position counter with index and period reset handling.
    // [RULE9] Count held when off
    always @(posedge clk) begin
        if (rst) begin
            position_count_q <= 16'h0000;
            pos_evt_q <= 1'b0;
            err_flag_q <= 1'b0;
        end else begin
            pos_evt_q <= 1'b0;
            if (step) begin
                if (mode_index && dir_c && index_fwd_q) begin
                    // [RULE5] Forward index clear
                    position_count_q <= 16'h0000;
                    pos_evt_q <= 1'b1;
                end else if (mode_index && !dir_c && index_rev_q) begin
                    // [RULE6] Reverse index load
                    position_count_q <= period_limit_q;
                    pos_evt_q <= 1'b1;
                end else if (!mode_index && dir_c &&
                             (at_limit || at_ones)) begin
                    // [RULE7] Forward period clear
                    // [RULE10] Match or rollover event
                    position_count_q <= 16'h0000;
                    pos_evt_q <= 1'b1;
                end else if (!mode_index && !dir_c && at_zero) begin
                    // [RULE8] Reverse period load
                    position_count_q <= period_limit_q;
                    pos_evt_q <= 1'b1;
                end else if (dir_c) begin
                    // Ordinary step forward.
                    position_count_q <= position_count_q + 16'h0001;
                end else begin
                    // Ordinary step backward.
                    position_count_q <= position_count_q - 16'h0001;
                end
            end
            // A rollover in the same cycle wins over a clear.
            if (err_set) begin
                err_flag_q <= 1'b1;
            end else if (wr_pend_q && addr_q == `QPV_OFS_STATUS &&
                         hwdata[`QPV_ST_ERR_BIT]) begin
                err_flag_q <= 1'b0;
            end
            // Software may load the count; its write wins over a step.
            if (wr_pend_q && addr_q == `QPV_OFS_POSITION)
                position_count_q <= hwdata[15:0];
        end
    end

    // Velocity postscaler.
    // [RULE22] Divide velocity pulses
    qpv_postscale u_post (.clk(clk), .rst(rst), .enable(vel_on),
        .ratio(ratio_q), .pulse_in(vel_raw), .pulse_out(velocity_pulse));

    // Speed timer, captured and cleared on each divided pulse.
    always @(posedge clk) begin
        if (rst) begin
            speed_timer_q <= 16'h0000;
            velocity_capture_q <= 16'h0000;
        end else if (velocity_pulse) begin
            // [RULE18] Capture buffer reuse
            // [RULE20] Capture then clear
            velocity_capture_q <= speed_timer_q;
            speed_timer_q <= 16'h0000;
        end else if (vel_on) begin
            speed_timer_q <= speed_timer_q + 16'h0001;
        end
    end

    // Sticky flags: a set in the same cycle wins over a clear.
    // [RULE13] One-cycle pulse latched
    // [RULE14] Cleared only by software
    wire clr_wr = wr_pend_q && addr_q == `QPV_OFS_STATUS;
    always @(posedge clk) begin
        if (rst) begin
            pos_flag_q <= 1'b0;
            dir_flag_q <= 1'b0;
            vel_flag_q <= 1'b0;
        end else begin
            pos_flag_q <= pos_evt_q |
                (pos_flag_q & ~(clr_wr & hwdata[`QPV_ST_POS_BIT]));
            dir_flag_q <= dir_evt_q |
                (dir_flag_q & ~(clr_wr & hwdata[`QPV_ST_DIR_BIT]));
            vel_flag_q <= velocity_pulse |
                (vel_flag_q & ~(clr_wr & hwdata[`QPV_ST_VEL_BIT]));
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY.
    wire take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rotation_direction = up_q;

    // Latch the address phase and apply control writes.
    always @(posedge clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            mode_q <= `QPV_MODE_OFF;
            ratio_q <= 2'h0;
            velocity_disable_q <= 1'b0;
            period_limit_q <= `QPV_RST_LIMIT;
        end else begin
            wr_pend_q <= take && hwrite;
            if (take)
                addr_q <= haddr;
            // A control write takes effect at the end of its data phase.
            if (wr_pend_q && addr_q == `QPV_OFS_CONTROL) begin
                ratio_q <= hwdata[`QPV_CTL_DIV_LSB +: 2];
                mode_q <= hwdata[`QPV_CTL_MODE_LSB +: 3];
                velocity_disable_q <= hwdata[`QPV_CTL_VDIS_BIT];
            end
            // The period limit takes effect the same way.
            if (wr_pend_q && addr_q == `QPV_OFS_LIMIT)
                period_limit_q <= hwdata[15:0];
        end
    end

    // Registered read data for the next data phase.
    always @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            case (haddr)
                // Control word with the read-only status bits in it.
                `QPV_OFS_CONTROL:
                    hrdata <= {24'h000000, velocity_disable_q,
                               err_flag_q, up_q, mode_q, ratio_q};
                // Sticky flags and the direction level.
                `QPV_OFS_STATUS:
                    hrdata <= {27'h0000000, up_q, vel_flag_q,
                               err_flag_q, dir_flag_q, pos_flag_q};
                // Current position count.
                `QPV_OFS_POSITION:
                    hrdata <= {16'h0000, position_count_q};
                // Period limit.
                `QPV_OFS_LIMIT:
                    hrdata <= {16'h0000, period_limit_q};
                // Last captured timer value.
                `QPV_OFS_VELOCITY:
                    hrdata <= {16'h0000, velocity_capture_q};
                // Running speed timer.
                `QPV_OFS_TIMER:
                    hrdata <= {16'h0000, speed_timer_q};
                // Unmapped addresses read as zero.
                default:
                    hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// File: tb/qpv_enc_model.sv
// Behavioural incremental encoder with an index mark on three pins.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module qpv_enc_model (
    output reg phase_a,
    output reg phase_b,
    output reg index_input
);
    // Place in the quadrature cycle; forward runs 00, 10, 11, 01.
    reg [1:0] st_q;
    // The pins rest low at start.
    initial begin
        st_q = 2'h0;
        phase_a = 1'b0;
        phase_b = 1'b0;
        index_input = 1'b0;
    end
    // Quarter spacing floor.
    // One quarter step 3 ns off the edge, held at least four cycles.
    task step(input bit fwd, input int qtr);
        begin
            #3;
            st_q = fwd ? st_q + 2'h1 : st_q - 2'h1;
            phase_a = st_q[1] ^ st_q[0];
            phase_b = st_q[1];
            #(((qtr < 4) ? 4 : qtr) * 8 - 3);
        end
    endtask
    // Moves the index mark off the clock edge.
    task set_index(input bit v);
        begin
            #3;
            index_input = v;
        end
    endtask
endmodule

// File: tb/qpv_monitor.sv
// Checker for the quadrature block, seeing only the top module's ports.
// Assumes one AHB-Lite master and pin moves at least five cycles apart.
`timescale 1ns/10ps
module qpv_monitor (
    input wire clk,
    input wire rst,
    input wire phase_a,
    input wire phase_b,
    input wire index_input,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire rotation_direction,
    input wire velocity_pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // A bus request is taken at this edge.
    wire take = hsel & hready & htrans[1];
    // Data phase flags, its address, cycles since a pin moved, control shadow.
    reg wr_q, rd_q;
    reg [7:0] ra_q, ctl_q;
    reg [3:0] mv_q, age_q;
    // Modes 001, 010, 101 and 110 run; the others leave the logic idle.
    wire mode_on = ctl_q[3] ^ ctl_q[2];
    // Shadows the bus; a control write lands at the end of its data phase.
    always @(posedge clk) begin
        if ($changed(phase_a) || $changed(phase_b)) begin
            mv_q <= 4'h0;
        end else if (mv_q != 4'hf) begin
            mv_q <= mv_q + 4'h1;
        end
        wr_q <= take & hwrite;
        rd_q <= take & ~hwrite;
        ra_q <= haddr;
        if (rst) begin
            mv_q <= 4'hf;
            ctl_q <= 8'h00;
            age_q <= 4'h0;
        end else if (wr_q && ra_q == 8'h00) begin
            ctl_q <= hwdata[7:0];
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end
    okay_ready_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    rdata_hold_a: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_q && ra_q > 8'h14 |-> hrdata == 0)
        else $error("unmapped read not zero");
    ctl_readback_a: assert property (
        rd_q && ra_q == 8'h00 |-> {hrdata[7], hrdata[4:0]} ==
        {ctl_q[7], ctl_q[4:0]}) else $error("control read back wrong");
    dir_cause_a: assert property (
        $changed(rotation_direction) |-> mv_q inside {[1:6]})
        else $error("direction moved without a pin edge");
    vel_cause_a: assert property (
        velocity_pulse |-> mv_q inside {[1:7]})
        else $error("velocity pulse without a pin edge");
    vel_single_a: assert property (
        velocity_pulse |=> !velocity_pulse)
        else $error("velocity pulse longer than a cycle");
    off_quiet_a: assert property (
        age_q == 4'hf |-> (mode_on && !ctl_q[7] || !velocity_pulse) &&
        (mode_on || $stable(rotation_direction))) else $error("idle not quiet");
endmodule
bind qpv_top qpv_monitor mon_u (.clk(clk), .rst(rst), .phase_a(phase_a),
    .phase_b(phase_b), .index_input(index_input), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .rotation_direction(rotation_direction), .velocity_pulse(velocity_pulse));

// File: tb/quadrature_position_velocity_tb.sv
// Self-checking bench for the quadrature position and velocity block.
// Assumes the encoder model and the bound checker are compiled first.
`timescale 1ns/10ps
module quadrature_position_velocity_tb;
    // Clock, reset and bus master outputs, all set at time zero.
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg rd_p = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, phase_a, phase_b, index_input, dir, vel;
    // Expected read ranges, oldest first, and the tallies.
    reg [31:0] lo_q[$];
    reg [31:0] hi_q[$];
    integer n_mismatch = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    integer vel_cnt = 0;
    integer n0, r, rv;
    qpv_enc_model enc_u (.phase_a(phase_a), .phase_b(phase_b),
        .index_input(index_input));
    qpv_top dut_u (.clk(clk), .rst(rst), .phase_a(phase_a),
        .phase_b(phase_b), .index_input(index_input), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .rotation_direction(dir), .velocity_pulse(vel));
    // The 125 MHz clock.
    always #4 clk = ~clk;
    // Counts pulses, checks read data against the oldest note, stops hangs.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (vel === 1'b1) begin
            vel_cnt = vel_cnt + 1;
        end
        if (rd_p && hreadyout === 1'b1) begin
            cmp_count = cmp_count + 1;
            if (((hrdata >= lo_q[0]) && (hrdata <= hi_q[0])) !== 1'b1) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t got %h exp %h", $time, hrdata, lo_q[0]);
            end
            lo_q.delete(0);
            hi_q.delete(0);
        end
        if (hreadyout === 1'b1) begin
            rd_p = hsel & htrans[1] & ~hwrite;
        end
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end
    // Prints the verdict and ends the run.
    task close_out;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compares a value the bench samples or tallies itself.
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single-word transfer; a read notes its range lo to hi.
    task xfer(input bit w, input [7:0] a, input [31:0] lo, input [31:0] hi);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= lo;
        if (!w) begin
            lo_q.push_back(lo);
            hi_q.push_back(hi);
        end
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(1'b1, a, d, d);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        xfer(1'b0, a, e, e);
    endtask
    // Writes the count and clears every status flag.
    task setpos(input [31:0] p);
        wr(8'h08, p);
        wr(8'h04, 32'h1f);
    endtask
    // Moves n quarters, spaced q cycles or at random, then lets it settle.
    task mv(input int n, input bit fwd, input int q);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            enc_u.step(fwd, (q != 0) ? q : 5 + $urandom % 5);
        end
        repeat (8) @(posedge clk);
    endtask
    // Index mark up or down, then a few cycles to be seen.
    task idx(input bit v);
        enc_u.set_index(v);
        repeat (6) @(posedge clk);
    endtask
    // Reset, register checks, then the encoder scenarios in turn.
    initial begin
        rv = $urandom(68);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h0);
        rd(8'h0c, 32'hffff);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h18, 32'h0);
        wr(8'h10, 32'h1234);
        rd(8'h10, 32'h0);
        // Period mode x4 with velocity off; first edges settle direction.
        wr(8'h0c, 32'h5);
        wr(8'h00, 32'h98);
        mv(2, 1, 0);
        setpos(0);
        mv(5, 1, 0);
        rd(8'h08, 32'h5);
        rd(8'h04, 32'h10);
        chk(dir, 1);
        mv(1, 1, 0);
        rd(8'h08, 32'h0);
        repeat (20) @(posedge clk);
        rd(8'h04, 32'h11);
        setpos(32'hffff);
        mv(1, 1, 0);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h11);
        mv(2, 0, 0);
        setpos(2);
        mv(2, 0, 0);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0);
        chk(dir, 0);
        mv(1, 0, 0);
        rd(8'h08, 32'h5);
        rd(8'h04, 32'h1);
        wr(8'h04, 32'h1f);
        mv(2, 1, 0);
        xfer(1'b0, 8'h04, 32'h12, 32'h13);
        // Off keeps the count, and so does a mode change.
        rv = $urandom % 32768;
        setpos(rv);
        wr(8'h00, 32'h80);
        mv(3, 1, 0);
        rd(8'h08, rv);
        wr(8'h00, 32'h94);
        rd(8'h08, rv);
        mv(2, 1, 0);
        setpos(32'hffff);
        mv(1, 1, 0);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h14);
        setpos(32'h40);
        idx(1);
        mv(1, 1, 0);
        idx(0);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h11);
        mv(2, 0, 0);
        setpos(32'h20);
        idx(1);
        idx(0);
        mv(1, 0, 0);
        rd(8'h08, 32'h5);
        rd(8'h04, 32'h1);
        // Velocity on: x2 counts phase_a edges only.
        wr(8'h0c, 32'h100);
        wr(8'h00, 32'h08);
        mv(4, 1, 0);
        setpos(32'h10);
        n0 = vel_cnt;
        mv(4, 1, 0);
        rd(8'h08, 32'h12);
        chk(vel_cnt - n0, 2);
        // Index mode x2 keeps skipping phase_b edges.
        wr(8'h00, 32'h04);
        setpos(32'h10);
        n0 = vel_cnt;
        mv(4, 1, 0);
        rd(8'h08, 32'h12);
        chk(vel_cnt - n0, 2);
        for (r = 0; r < 4; r = r + 1) begin
            wr(8'h00, 32'h18 + r);
            n0 = vel_cnt;
            mv(4 << (2 * r), 1, 0);
            chk(vel_cnt - n0, 4);
        end
        wr(8'h00, 32'h19);
        mv(8, 1, 6);
        xfer(1'b0, 8'h10, 32'd22, 32'd25);
        wr(8'h00, 32'h99);
        n0 = vel_cnt;
        mv(8, 1, 0);
        chk(vel_cnt - n0, 0);
        close_out();
    end
endmodule
